/* File: rtl/oscp_pkg.sv */
// constants for the offset, slicer, input and power control register bank
package oscp_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] OSCP_IDX_OFFSET    = 8'h1B;
    localparam logic [7:0] OSCP_IDX_SLICER    = 8'h1D;
    localparam logic [7:0] OSCP_IDX_INPWR     = 8'h1E;
    localparam logic [7:0] OSCP_IDX_DETECT    = 8'h24;
    localparam logic [7:0] OSCP_IDX_IRQ_STAT  = 8'h30;
    localparam logic [7:0] OSCP_IDX_IRQ_MASK  = 8'h31;

    // reset values
    localparam logic [7:0] OSCP_RST_OFFSET    = 8'h5B;
    localparam logic [7:0] OSCP_RST_SLICER    = 8'h78;
    localparam logic [7:0] OSCP_RST_INPWR     = 8'h20;
    localparam logic [7:0] OSCP_RST_MASK      = 8'h00;

    // offset_loop_control fields
    localparam int OSCP_AUTO_OFS_BIT = 5;
    localparam int OSCP_RATE_LSB     = 3;
    localparam int OSCP_RATE_MSB     = 4;

    // update rate codes
    localparam logic [1:0] OSCP_RATE_EVERY = 2'h0;
    localparam logic [1:0] OSCP_RATE_16    = 2'h1;
    localparam logic [1:0] OSCP_RATE_64    = 2'h2;
    localparam logic [1:0] OSCP_RATE_VSYNC = 2'h3;
    localparam logic [5:0] OSCP_LAST_16    = 6'h0F;
    localparam logic [5:0] OSCP_LAST_64    = 6'h3F;

    // green_sync_slicer_control fields
    localparam int OSCP_THR_LSB     = 3;
    localparam int OSCP_THR_MSB     = 7;
    localparam int OSCP_SLC_POL_BIT = 2;
    localparam int OSCP_SLC_SEL_LSB = 0;
    localparam int OSCP_SLC_SEL_MSB = 1;
    localparam int OSCP_THR_STEP_SH = 3;   // 8 mV per code step

    // slicer output selector codes
    localparam logic [1:0] OSCP_SEL_RAW_SLICER = 2'h0;
    localparam logic [1:0] OSCP_SEL_RAW_HSYNC  = 2'h1;
    localparam logic [1:0] OSCP_SEL_REGEN      = 2'h2;
    localparam logic [1:0] OSCP_SEL_FILTERED   = 2'h3;

    // input_and_power_control fields
    localparam int OSCP_CH_OVR_BIT   = 7;
    localparam int OSCP_CH_SEL_BIT   = 6;
    localparam int OSCP_BW_BIT       = 5;
    localparam int OSCP_PD_AUTO_BIT  = 4;
    localparam int OSCP_PD_BIT       = 3;
    localparam int OSCP_PD_POL_BIT   = 2;
    localparam int OSCP_FAST_SW_BIT  = 1;
    localparam int OSCP_SLC_HIZ_BIT  = 0;

    // activity detect bits in the detect register
    localparam int OSCP_DET_H0_BIT = 7;
    localparam int OSCP_DET_H1_BIT = 6;
    localparam int OSCP_DET_G0_BIT = 3;
    localparam int OSCP_DET_G1_BIT = 2;

    // interrupt status bits
    localparam int OSCP_IRQ_PWR_BIT = 0;
    localparam int OSCP_IRQ_ACT_BIT = 1;
    localparam int OSCP_IRQ_UPD_BIT = 2;

    // an input counts as active this long after a toggle
    localparam int OSCP_CLK_MHZ      = 50;
    localparam int OSCP_ACT_WIN_US   = 100;
    localparam int OSCP_ACT_WIN_CYC  = OSCP_ACT_WIN_US * OSCP_CLK_MHZ;
    localparam int OSCP_ACT_CNT_W    = 13;

    // axi answers
    localparam logic [1:0] OSCP_RESP_OKAY   = 2'h0;
    localparam logic [1:0] OSCP_RESP_SLVERR = 2'h2;
    localparam int         OSCP_ADDR_W      = 10;

endpackage : oscp_pkg

/* File: rtl/oscp_ctrl.sv */
// offset, slicer, input and power-down control over axi4-lite
//
// The AXI4-Lite interface to the registers was decided locally.
module oscp_ctrl
    import oscp_pkg::*;
#(
    parameter int ACT_WIN_CYC = OSCP_ACT_WIN_CYC
) (
    input  wire logic                   sys_clk,
    input  wire logic                   rst,
    input  wire logic                   ce,
    // axi4-lite slave
    input  wire logic [OSCP_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [OSCP_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // sync inputs and internal sync sources
    input  wire logic                   horizontal_sync_in0,
    input  wire logic                   horizontal_sync_in1,
    input  wire logic                   green_channel_sync_in0,
    input  wire logic                   green_channel_sync_in1,
    input  wire logic                   regen_sync_in,
    input  wire logic                   filtered_sync_in,
    input  wire logic                   auto_channel_in,
    input  wire logic                   clamp_tick,
    input  wire logic                   vsync_tick,
    input  wire logic                   power_down_pin,
    // outputs
    output logic                        slicer_sync_output_pin,
    output logic                        slicer_sync_output_oe,
    output logic                        active_channel,
    output logic                        auto_offset_enable,
    output logic                        offset_update_pulse,
    output logic [4:0]                  slicer_threshold_code,
    output logic [8:0]                  slicer_threshold_mv,
    output logic                        input_bandwidth_high,
    output logic                        core_power_down,
    output logic                        data_outputs_hiz,
    output logic                        irq
);

    ////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [7:0]                      ofs_ctl;
        logic [7:0]                      slc_ctl;
        logic [7:0]                      inp_ctl;
        logic [7:0]                      irq_stat;
        logic [7:0]                      irq_mask;
        logic                            irq;
        // axi
        logic                            aw_have;
        logic [OSCP_ADDR_W-1:0]          aw_addr;
        logic                            w_have;
        logic [7:0]                      w_data;
        logic                            w_lane0;
        logic                            awready;
        logic                            wready;
        logic                            bvalid;
        logic [1:0]                      bresp;
        logic                            arready;
        logic                            rvalid;
        logic [31:0]                     rdata;
        logic [1:0]                      rresp;
        // activity detection
        logic [3:0]                      act_prev;
        logic [3:0][OSCP_ACT_CNT_W-1:0]  act_cnt;
        logic [3:0]                      act;
        // offset loop
        logic [5:0]                      clamp_cnt;
        logic                            upd;
        // power and pins
        logic                            pd_meta;
        logic                            pd_sync;
        logic                            pd_req;
        logic                            core_pd;
        logic                            out_hiz;
        logic                            slc_pin;
        logic                            slc_oe;
        logic                            chan;
        logic [4:0]                      thr_code;
        logic [8:0]                      thr_mv;
    } oscp_state_type;

    oscp_state_type state_reg;
    oscp_state_type state_next;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // byte address to register index; low bits ignored
    function automatic logic [7:0] oscp_index(
        input logic [OSCP_ADDR_W-1:0] addr
    );
        oscp_index = addr[OSCP_ADDR_W-1:2];
    endfunction : oscp_index

    // index hits a register of the bank
    function automatic logic oscp_mapped(input logic [7:0] idx);
        oscp_mapped = (idx == OSCP_IDX_OFFSET) || (idx == OSCP_IDX_SLICER)
            || (idx == OSCP_IDX_INPWR) || (idx == OSCP_IDX_DETECT)
            || (idx == OSCP_IDX_IRQ_STAT) || (idx == OSCP_IDX_IRQ_MASK);
    endfunction : oscp_mapped

    // last count of clamp periods before an offset refresh
    function automatic logic [5:0] oscp_last(input logic [1:0] rate);
        unique case (rate)
            OSCP_RATE_16: oscp_last = OSCP_LAST_16;
            OSCP_RATE_64: oscp_last = OSCP_LAST_64;
            default:      oscp_last = 6'h00;
        endcase
    endfunction : oscp_last

    // layout of the detect register
    function automatic logic [7:0] oscp_detect(input logic [3:0] act);
        oscp_detect = 8'h00;
        oscp_detect[OSCP_DET_H0_BIT] = act[0];
        oscp_detect[OSCP_DET_H1_BIT] = act[1];
        oscp_detect[OSCP_DET_G0_BIT] = act[2];
        oscp_detect[OSCP_DET_G1_BIT] = act[3];
    endfunction : oscp_detect

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [7:0]  widx;
        logic [7:0]  ridx;
        logic [7:0]  rval;
        logic [7:0]  events;
        logic [7:0]  clr;
        logic [3:0]  sync_now;
        logic [1:0]  rate;
        logic        pin_act;
        logic        pd_now;
        logic        src;
        logic        sel_hs;
        logic        sel_gs;
        logic        do_write;
        widx     = oscp_index(state_reg.aw_addr);
        ridx     = oscp_index(s_axi_araddr);
        rval     = 8'h00;
        events   = 8'h00;
        clr      = 8'h00;
        sync_now = {green_channel_sync_in1, green_channel_sync_in0,
                    horizontal_sync_in1, horizontal_sync_in0};
        rate     = state_reg.ofs_ctl[OSCP_RATE_MSB:OSCP_RATE_LSB];
        pin_act  = 1'b0;
        pd_now   = 1'b0;
        src      = 1'b0;
        sel_hs   = 1'b0;
        sel_gs   = 1'b0;
        do_write = 1'b0;
        state_next = state_reg;

        // address and data are taken in either order
        if (s_axi_awvalid && state_reg.awready) begin
            state_next.aw_have = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && state_reg.wready) begin
            state_next.w_have  = 1'b1;
            state_next.w_data  = s_axi_wdata[7:0];
            state_next.w_lane0 = s_axi_wstrb[0];
        end
        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end
        do_write = state_reg.aw_have && state_reg.w_have
            && !state_reg.bvalid;
        if (do_write) begin
            state_next.aw_have = 1'b0;
            state_next.w_have  = 1'b0;
            state_next.bvalid  = 1'b1;
            state_next.bresp   = oscp_mapped(widx) ? OSCP_RESP_OKAY
                                                   : OSCP_RESP_SLVERR;
            if (state_reg.w_lane0) begin
                unique case (widx)
                    OSCP_IDX_OFFSET:   state_next.ofs_ctl = state_reg.w_data;
                    OSCP_IDX_SLICER:   state_next.slc_ctl = state_reg.w_data;
                    OSCP_IDX_INPWR:    state_next.inp_ctl = state_reg.w_data;
                    OSCP_IDX_IRQ_STAT: clr = state_reg.w_data;
                    OSCP_IDX_IRQ_MASK: state_next.irq_mask = state_reg.w_data;
                    default:           clr = 8'h00;
                endcase
            end
        end
        // no new write until the response is accepted
        state_next.awready = !state_next.aw_have && !state_next.bvalid;
        state_next.wready  = !state_next.w_have && !state_next.bvalid;

        // read data follows the address edge
        if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && state_reg.arready) begin
            unique case (ridx)
                OSCP_IDX_OFFSET:   rval = state_reg.ofs_ctl;
                OSCP_IDX_SLICER:   rval = state_reg.slc_ctl;
                OSCP_IDX_INPWR:    rval = state_reg.inp_ctl;
                OSCP_IDX_DETECT:   rval = oscp_detect(state_reg.act);
                OSCP_IDX_IRQ_STAT: rval = state_reg.irq_stat;
                OSCP_IDX_IRQ_MASK: rval = state_reg.irq_mask;
                default:           rval = 8'h00;
            endcase
            state_next.rvalid = 1'b1;
            state_next.rdata  = {24'h000000, rval};
            state_next.rresp  = oscp_mapped(ridx) ? OSCP_RESP_OKAY
                                                  : OSCP_RESP_SLVERR;
        end
        state_next.arready = !state_next.rvalid;

        // a toggle reloads the window; a steady level lets it expire
        for (int i = 0; i < 4; i++) begin
            state_next.act_prev[i] = sync_now[i];
            if (sync_now[i] != state_reg.act_prev[i]) begin
                state_next.act_cnt[i] = ACT_WIN_CYC[OSCP_ACT_CNT_W-1:0];
                state_next.act[i]     = 1'b1;
            end else if (state_reg.act_cnt[i] != '0) begin
                state_next.act_cnt[i] = state_reg.act_cnt[i]
                                        - {{(OSCP_ACT_CNT_W-1){1'b0}}, 1'b1};
            end else begin
                state_next.act[i] = 1'b0;
            end
        end

        // refresh pulses only with auto offset on
        state_next.upd = 1'b0;
        if (!state_reg.ofs_ctl[OSCP_AUTO_OFS_BIT]) begin
            state_next.clamp_cnt = 6'h00;
        end else if (rate == OSCP_RATE_VSYNC) begin
            state_next.clamp_cnt = 6'h00;
            state_next.upd       = vsync_tick;
        end else if (clamp_tick) begin
            if (state_reg.clamp_cnt >= oscp_last(rate)) begin
                state_next.clamp_cnt = 6'h00;
                state_next.upd       = 1'b1;
            end else begin
                state_next.clamp_cnt = state_reg.clamp_cnt + 6'h01;
            end
        end

        // two-flop synchroniser; only pd_sync feeds logic
        state_next.pd_meta = power_down_pin;
        state_next.pd_sync = state_reg.pd_meta;

        // power-down decision
        pin_act = state_reg.inp_ctl[OSCP_PD_POL_BIT]
            ? state_reg.pd_sync : !state_reg.pd_sync;
        if (state_reg.inp_ctl[OSCP_PD_AUTO_BIT]) begin
            pd_now = !(|state_reg.act);
        end else begin
            pd_now = state_reg.inp_ctl[OSCP_PD_BIT] || pin_act;
        end
        state_next.pd_req = pd_now;
        // fast switching keeps the core up, floats the outputs
        state_next.core_pd = pd_now
            && !state_reg.inp_ctl[OSCP_FAST_SW_BIT];
        state_next.out_hiz = pd_now;
        state_next.slc_oe  = !(pd_now
            && state_reg.inp_ctl[OSCP_SLC_HIZ_BIT]);

        // channel choice
        state_next.chan = state_reg.inp_ctl[OSCP_CH_OVR_BIT]
            ? state_reg.inp_ctl[OSCP_CH_SEL_BIT]
            : auto_channel_in;
        sel_hs = state_reg.chan ? horizontal_sync_in1 : horizontal_sync_in0;
        sel_gs = state_reg.chan ? green_channel_sync_in1
                                : green_channel_sync_in0;

        // slicer source; the upstream filter inserts and drops pulses
        unique case (state_reg.slc_ctl[OSCP_SLC_SEL_MSB:OSCP_SLC_SEL_LSB])
            OSCP_SEL_RAW_SLICER: src = sel_gs;
            OSCP_SEL_RAW_HSYNC:  src = sel_hs;
            OSCP_SEL_REGEN:      src = regen_sync_in;
            OSCP_SEL_FILTERED:   src = filtered_sync_in;
        endcase
        state_next.slc_pin = state_reg.slc_ctl[OSCP_SLC_POL_BIT]
            ? src : !src;

        // threshold code and millivolts, (code + 1) * 8
        state_next.thr_code = state_reg.slc_ctl[OSCP_THR_MSB:OSCP_THR_LSB];
        state_next.thr_mv   = {({1'b0, state_next.thr_code} + 6'h01),
                               3'b000};

        // sticky events; a set in the clearing cycle wins
        events[OSCP_IRQ_PWR_BIT] = pd_now != state_reg.pd_req;
        events[OSCP_IRQ_ACT_BIT] = state_next.act != state_reg.act;
        events[OSCP_IRQ_UPD_BIT] = state_reg.upd;
        state_next.irq_stat = (state_reg.irq_stat & ~clr) | events;
        state_next.irq = |(state_next.irq_stat & state_next.irq_mask);
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    // ce low freezes all state, axi handshake too
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg          <= '0;
            state_reg.ofs_ctl  <= OSCP_RST_OFFSET;
            state_reg.slc_ctl  <= OSCP_RST_SLICER;
            state_reg.inp_ctl  <= OSCP_RST_INPWR;
            state_reg.irq_mask <= OSCP_RST_MASK;
            state_reg.awready  <= 1'b1;
            state_reg.wready   <= 1'b1;
            state_reg.arready  <= 1'b1;
            state_reg.slc_oe   <= 1'b1;
            state_reg.pd_meta  <= 1'b1;
            state_reg.pd_sync  <= 1'b1;
            state_reg.thr_code <= 5'h0F;
            state_reg.thr_mv   <= 9'h080;
        end else if (ce) begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all from flops

    assign s_axi_awready          = state_reg.awready;
    assign s_axi_wready           = state_reg.wready;
    assign s_axi_bresp            = state_reg.bresp;
    assign s_axi_bvalid           = state_reg.bvalid;
    assign s_axi_arready          = state_reg.arready;
    assign s_axi_rdata            = state_reg.rdata;
    assign s_axi_rresp            = state_reg.rresp;
    assign s_axi_rvalid           = state_reg.rvalid;
    assign slicer_sync_output_pin = state_reg.slc_pin;
    assign slicer_sync_output_oe  = state_reg.slc_oe;
    assign active_channel         = state_reg.chan;
    assign auto_offset_enable     = state_reg.ofs_ctl[OSCP_AUTO_OFS_BIT];
    assign offset_update_pulse    = state_reg.upd;
    assign slicer_threshold_code  = state_reg.thr_code;
    assign slicer_threshold_mv    = state_reg.thr_mv;
    assign input_bandwidth_high   = state_reg.inp_ctl[OSCP_BW_BIT];
    assign core_power_down        = state_reg.core_pd;
    assign data_outputs_hiz       = state_reg.out_hiz;
    assign irq                    = state_reg.irq;

endmodule : oscp_ctrl

/* File: sim/oscp_sync_src.sv */
// sync source: clamp and vsync ticks, hsync while running
module oscp_sync_src (
    input  wire logic sys_clk,
    input  wire logic hs_run,
    output logic      horizontal_sync_in0,
    output logic      clamp_tick,
    output logic      vsync_tick
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] cnt_reg = 6'h00;
    initial horizontal_sync_in0 = 1'b0;
    // a stopped line holds its level, so no edge reaches the detector
    always @(posedge sys_clk) begin
        cnt_reg <= cnt_reg + 6'h01;
        clamp_tick <= (cnt_reg[1:0] == 2'h3);
        vsync_tick <= (cnt_reg == 6'h3F);
        if (hs_run && cnt_reg[2:0] == 3'h7)
            horizontal_sync_in0 <= ~horizontal_sync_in0;
    end
endmodule : oscp_sync_src

/* File: sim/oscp_ctrl_chk.sv */
// assertions on bus handshakes and derived outputs
module oscp_ctrl_chk (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        slicer_sync_output_oe,
    input wire logic        offset_update_pulse,
    input wire logic        clamp_tick,
    input wire logic        vsync_tick,
    input wire logic [4:0]  slicer_threshold_code,
    input wire logic [8:0]  slicer_threshold_mv,
    input wire logic        core_power_down,
    input wire logic        data_outputs_hiz
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_rd_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("early read address");
    a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response not held");
    a_upd_cause: assert property (offset_update_pulse
        |-> $past(clamp_tick) || $past(vsync_tick))
        else $error("update without tick");
    a_thr_map: assert property ($stable(slicer_threshold_code)[*2]
        |-> slicer_threshold_mv == {slicer_threshold_code, 3'h0} + 9'h008)
        else $error("threshold mv mismatch");
    a_core_hiz: assert property (core_power_down |-> data_outputs_hiz)
        else $error("core down, outputs driven");
    a_oe_pd: assert property (!slicer_sync_output_oe |-> data_outputs_hiz)
        else $error("pin floats outside power-down");
    c_pd: cover property (core_power_down);
    c_upd: cover property (offset_update_pulse);
    c_oe: cover property (!slicer_sync_output_oe);
endmodule : oscp_ctrl_chk

bind oscp_ctrl oscp_ctrl_chk i_oscp_ctrl_chk (.sys_clk, .rst, .s_axi_arvalid,
    .s_axi_arready, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .slicer_sync_output_oe, .offset_update_pulse, .clamp_tick,
    .vsync_tick, .slicer_threshold_code, .slicer_threshold_mv,
    .core_power_down, .data_outputs_hiz);

/* File: sim/oscp_ctrl_tb.sv */
// self-checking bench for the control bank
module oscp_ctrl_tb
    import oscp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, rst = 1'b1, ce = 1'b1, hs_run = 1'b0;
    logic [9:0]  s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
    logic [4:0]  slicer_threshold_code, thr;
    logic [8:0]  slicer_threshold_mv;
    logic [7:0]  rd_data;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, regen_sync_in = 1'b0;
    logic horizontal_sync_in1 = 1'b0, green_channel_sync_in0 = 1'b0;
    logic green_channel_sync_in1 = 1'b0, filtered_sync_in = 1'b0;
    logic auto_channel_in = 1'b0, power_down_pin = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, horizontal_sync_in0, clamp_tick, vsync_tick;
    logic slicer_sync_output_pin, slicer_sync_output_oe, active_channel;
    logic auto_offset_enable, offset_update_pulse, input_bandwidth_high;
    logic core_power_down, data_outputs_hiz, irq;
    int   bad_count = 0, samples_checked = 0, pulses = 0;
    logic [7:0] chan_tab [3] = '{8'h20, 8'hA0, 8'hE0};
    // control, pin, expected pd, hiz, oe
    logic [11:0] pd_tab [8] = '{12'h28F, 12'h207, 12'h209, 12'h241,
        12'h24F, 12'h26B, 12'h27A, 12'h2D6};
    logic [7:0] ofs_tab [5] = '{8'h23, 8'h2B, 8'h33, 8'h3B, 8'h1B};
    int         ofs_cnt [5] = '{64, 4, 1, 4, 0};

    always #10 sys_clk = ~sys_clk;
    // counted on falling edge so a clear never races it
    always @(negedge sys_clk) if (offset_update_pulse === 1'b1) pulses++;

    oscp_ctrl #(.ACT_WIN_CYC(20)) i_oscp_ctrl (.sys_clk, .rst, .ce,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .horizontal_sync_in0, .horizontal_sync_in1,
        .green_channel_sync_in0, .green_channel_sync_in1, .regen_sync_in,
        .filtered_sync_in, .auto_channel_in, .clamp_tick, .vsync_tick,
        .power_down_pin, .slicer_sync_output_pin, .slicer_sync_output_oe,
        .active_channel, .auto_offset_enable, .offset_update_pulse,
        .slicer_threshold_code, .slicer_threshold_mv, .input_bandwidth_high,
        .core_power_down, .data_outputs_hiz, .irq);
    oscp_sync_src i_oscp_sync_src (.sys_clk, .hs_run, .horizontal_sync_in0,
        .clamp_tick, .vsync_tick);

    ////////////////////////////////////////////////////////////////////////
    // tasks
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
        end
    endtask : chk
    task automatic w(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : w
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        wr_resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge sys_clk);
    endtask : wr
    task automatic rd(input logic [9:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        rd_data = s_axi_rdata[7:0];
        rd_resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge sys_clk);
    endtask : rd
    task automatic rc(input logic [9:0] a, input logic [7:0] e);
        rd(a);
        chk("rdata", e, rd_data);
    endtask : rc
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    ////////////////////////////////////////////////////////////////////////
    // watchdog
    initial begin
        w(30000);
        bad_count++;
        summarize();
    end
    // test sequence
    initial begin
        w(6);
        rst <= 1'b0;
        w(1);
        rc(10'h06C, OSCP_RST_OFFSET);
        rc(10'h074, OSCP_RST_SLICER);
        rc(10'h078, OSCP_RST_INPWR);
        chk("mv", 32'h80, slicer_threshold_mv);
        rd(10'h3FC);
        chk("rresp", OSCP_RESP_SLVERR, rd_resp);
        wr(10'h3FC, 8'h01);
        chk("bresp", OSCP_RESP_SLVERR, wr_resp);
        $display("reset test done");
        green_channel_sync_in0 <= 1'b1;
        filtered_sync_in <= 1'b1;
        // sources 1,0,0,1: pin is parity of select and polarity
        for (int i = 0; i < 8; i++) begin
            thr = {i[2:0], i[1:0]};
            wr(10'h074, {thr, i[2:0]});
            w(3);
            chk("pin", ^i[2:0], slicer_sync_output_pin);
            chk("mv", {thr, 3'h0} + 9'h008, slicer_threshold_mv);
        end
        auto_channel_in <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            wr(10'h078, chan_tab[i]);
            w(3);
            chk("chan", i != 1, active_channel);
        end
        $display("slicer test done");
        for (int i = 0; i < 8; i++) begin
            power_down_pin <= pd_tab[i][3];
            wr(10'h078, pd_tab[i][11:4]);
            w(5);
            chk("pd", pd_tab[i][2], core_power_down);
            chk("hiz", pd_tab[i][1], data_outputs_hiz);
            chk("oe", pd_tab[i][0], slicer_sync_output_oe);
        end
        power_down_pin <= 1'b0;
        wr(10'h078, 8'h30);
        w(30);
        chk("pd", 1'b1, core_power_down);
        hs_run <= 1'b1;
        w(30);
        chk("pd", 1'b0, core_power_down);
        rc(10'h090, 8'h80);
        hs_run <= 1'b0;
        w(40);
        rc(10'h090, 8'h00);
        power_down_pin <= 1'b1;
        wr(10'h078, 8'h20);
        $display("power test done");
        for (int k = 0; k < 5; k++) begin
            wr(10'h06C, ofs_tab[k]);
            w(4);
            chk("aoe", k < 4, auto_offset_enable);
            pulses = 0;
            w(256);
            chk("pulses", ofs_cnt[k], pulses);
        end
        $display("offset test done");
        chk("irq", 1'b0, irq);
        wr(10'h0C4, 8'h04);
        w(2);
        chk("irq", 1'b1, irq);
        wr(10'h0C0, 8'hFF);
        w(2);
        chk("irq", 1'b0, irq);
        rc(10'h0C0, 8'h00);
        $display("irq test done");
        summarize();
    end
endmodule : oscp_ctrl_tb
